//--- pofade_led_model.sv
// led model: measures lit cycles of each active-low output per 100-cycle pwm period
// assumes a level holds for whole periods while it is measured
module pofade_led_model
  import pofade_pkg::*;
(
  input  wire logic                     clk_i,    // core clock
  input  wire logic                     clr_i,    // restart measuring
  input  wire logic [NUM_OUTS-1:0]      led_n_i,  // led lines, low lit
  output logic      [NUM_OUTS-1:0][6:0] level_o,  // last full period
  output logic      [NUM_OUTS-1:0][6:0] peak_o    // highest since clear
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_OUTS-1:0][6:0] cnt_reg;
  logic [6:0]               ph_reg;
  logic [6:0]               v;
  initial begin
    cnt_reg = '0;
    ph_reg  = '0;
    level_o = '0;
    peak_o  = '0;
  end
  always @(posedge clk_i) begin
    ph_reg <= (clr_i || ph_reg == 7'h63) ? 7'h00 : ph_reg + 7'h01;
    for (int i = 0; i < NUM_OUTS; i++) begin
      // a lit led pulls its line low
      v = cnt_reg[i] + {6'h00, ~led_n_i[i]};
      cnt_reg[i] <= (clr_i || ph_reg == 7'h63) ? 7'h00 : v;
      if (clr_i) begin
        peak_o[i] <= 7'h00;
      end else if (ph_reg == 7'h63) begin
        level_o[i] <= v;
        if (v > peak_o[i]) begin
          peak_o[i] <= v;
        end
      end
    end
  end
endmodule

//--- pofade_pkg.sv
// package for the power-on led fade block: register map, field layout, tables, timing
// assumes a single 50 MHz clock and an APB master with 32-bit data
// Notes on behaviour
// - the ramp-up time of a group's power-on effect is the fade slot picked by bits 7:6 of its first register.
// - the peak level comes from bits 5:3 of the first register, codes 0..7 giving 100,90,80,65,50,40,20,0 percent.
// - the effect cycle count comes from bits 2:0 of the first register, codes 0..7 giving 0,1,2,4,6,10,15,20 runs.
// - each register pair steers one output group: output 0 at 12h/13h, 1-3 at 14h/15h, 4-6 at 16h/17h, 7-9 at 18h/19h.
// - the ramp-down time is the fade slot picked by bits 7:6 of the second register, in code order.
// - the floor level comes from bits 5:3 of the second register, codes 0..7 giving 0,10,20,30,40,60,80,100 percent.
// - the hold time at peak is the fade slot picked by bits 2:1 of the second register.
// - the hold time at floor is fade slot one when bit 0 of the second register is 0, and slot two when it is 1.
// - the first register of each pair serves only the power-on effect.
package pofade_pkg;

  localparam int unsigned CLK_MHZ      = 50;
  localparam int unsigned TICK_US      = 1000;
  localparam int unsigned TICK_CYC     = TICK_US * CLK_MHZ;
  localparam int unsigned PWM_STEPS    = 100;
  localparam int unsigned HOLD_STEPS   = 100;
  localparam int unsigned NUM_GROUPS   = 4;
  localparam int unsigned NUM_OUTS     = 10;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CFG_A0    = 8'h12;
  localparam logic [7:0] IDX_CFG_B0    = 8'h13;
  localparam logic [7:0] IDX_CFG_A1    = 8'h14;
  localparam logic [7:0] IDX_CFG_B1    = 8'h15;
  localparam logic [7:0] IDX_CFG_A2    = 8'h16;
  localparam logic [7:0] IDX_CFG_B2    = 8'h17;
  localparam logic [7:0] IDX_CFG_A3    = 8'h18;
  localparam logic [7:0] IDX_CFG_B3    = 8'h19;
  localparam logic [7:0] IDX_FADE_SLOT = 8'h20;
  localparam logic [7:0] IDX_CTRL      = 8'h24;
  localparam logic [7:0] IDX_STATUS    = 8'h25;

  localparam logic [7:0] CFG_RST       = 8'h00;
  localparam logic [7:0] SLOT_RST      = 8'h0A;
  localparam int unsigned CTRL_START_BIT = 0;

  // field positions
  localparam int unsigned RISE_SEL_LSB = 6;
  localparam int unsigned PEAK_LSB     = 3;
  localparam int unsigned REPEAT_LSB   = 0;
  localparam int unsigned FALL_SEL_LSB = 6;
  localparam int unsigned FLOOR_LSB    = 3;
  localparam int unsigned PHOLD_LSB    = 1;
  localparam int unsigned FHOLD_BIT    = 0;

  typedef struct packed {
    logic [1:0] rise_duration_sel;
    logic [2:0] peak_code;
    logic [2:0] effect_cycle_count;
  } pofade_cfg_a_t;

  typedef struct packed {
    logic [1:0] fall_duration_sel;
    logic [2:0] floor_code;
    logic [1:0] peak_hold_sel;
    logic       floor_hold_sel;
  } pofade_cfg_b_t;

  // fade_slot_one .. fade_slot_four, in ticks per step
  typedef logic [3:0][7:0] pofade_slots_t;

  function automatic logic [6:0] pofade_peak_pct(input logic [2:0] code);
    case (code)
      3'h0:    pofade_peak_pct = 7'h64;
      3'h1:    pofade_peak_pct = 7'h5A;
      3'h2:    pofade_peak_pct = 7'h50;
      3'h3:    pofade_peak_pct = 7'h41;
      3'h4:    pofade_peak_pct = 7'h32;
      3'h5:    pofade_peak_pct = 7'h28;
      3'h6:    pofade_peak_pct = 7'h14;
      default: pofade_peak_pct = 7'h00;
    endcase
  endfunction

  function automatic logic [6:0] pofade_floor_pct(input logic [2:0] code);
    case (code)
      3'h0:    pofade_floor_pct = 7'h00;
      3'h1:    pofade_floor_pct = 7'h0A;
      3'h2:    pofade_floor_pct = 7'h14;
      3'h3:    pofade_floor_pct = 7'h1E;
      3'h4:    pofade_floor_pct = 7'h28;
      3'h5:    pofade_floor_pct = 7'h3C;
      3'h6:    pofade_floor_pct = 7'h50;
      default: pofade_floor_pct = 7'h64;
    endcase
  endfunction

  function automatic logic [4:0] pofade_runs(input logic [2:0] code);
    case (code)
      3'h0:    pofade_runs = 5'h00;
      3'h1:    pofade_runs = 5'h01;
      3'h2:    pofade_runs = 5'h02;
      3'h3:    pofade_runs = 5'h04;
      3'h4:    pofade_runs = 5'h06;
      3'h5:    pofade_runs = 5'h0A;
      3'h6:    pofade_runs = 5'h0F;
      default: pofade_runs = 5'h14;
    endcase
  endfunction

  // a slot of zero is taken as one tick so a step always ends
  function automatic logic [7:0] pofade_slot_len(input pofade_slots_t slots, input logic [1:0] sel);
    pofade_slot_len = (slots[sel] == 8'h00) ? 8'h01 : slots[sel];
  endfunction

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RISE  = 5'b00010,
    ST_PEAK  = 5'b00100,
    ST_FALL  = 5'b01000,
    ST_FLOOR = 5'b10000
  } pofade_state_t;

endpackage

//--- pofade_seq.sv
// one output group's power-on fade sequencer with its pwm comparator
// assumes tick_i is a one-cycle step enable and pwm_cnt_i counts 0..99
module pofade_seq
  import pofade_pkg::*;
(
  input  wire logic          clk_i,      // core clock
  input  wire logic          rst_i,      // synchronous reset, high
  input  wire logic          tick_i,     // step time enable
  input  wire logic          start_i,    // begin the effect
  input  wire pofade_cfg_a_t cfg_a_i,    // first config register
  input  wire pofade_cfg_b_t cfg_b_i,    // second config register
  input  wire pofade_slots_t slots_i,    // fade slot lengths
  input  wire logic [6:0]    pwm_cnt_i,  // pwm phase
  output logic               led_on_o,   // led lit, high
  output logic               busy_o      // effect running
);

  typedef struct packed {
    pofade_state_t st;
    logic [6:0]    level;
    logic [7:0]    sub;
    logic [6:0]    hold;
    logic [4:0]    runs;
    logic          on;
  } pofade_seq_t;

  pofade_seq_t s_reg;
  pofade_seq_t s_next;
  logic [7:0]  per;
  logic [6:0]  peak_lvl;
  logic [6:0]  floor_lvl;

  assign peak_lvl  = pofade_peak_pct(cfg_a_i.peak_code);
  assign floor_lvl = pofade_floor_pct(cfg_b_i.floor_code);

  always_comb begin
    unique case (s_reg.st)
      ST_RISE:  per = pofade_slot_len(slots_i, cfg_a_i.rise_duration_sel);
      ST_PEAK:  per = pofade_slot_len(slots_i, cfg_b_i.peak_hold_sel);
      ST_FALL:  per = pofade_slot_len(slots_i, cfg_b_i.fall_duration_sel);
      ST_FLOOR: per = pofade_slot_len(slots_i, {1'b0, cfg_b_i.floor_hold_sel});
      default:  per = 8'h01;
    endcase
  end

  always_comb begin
    s_next    = s_reg;
    s_next.on = (pwm_cnt_i < s_reg.level);
    if (start_i) begin
      s_next.runs  = pofade_runs(cfg_a_i.effect_cycle_count);
      s_next.st    = (s_next.runs == 5'h00) ? ST_IDLE : ST_RISE;
      s_next.level = 7'h00;
      s_next.sub   = 8'h00;
      s_next.hold  = 7'h00;
    end else if (tick_i && s_reg.st != ST_IDLE) begin
      s_next.sub = s_reg.sub + 8'h01;
      if (s_next.sub >= per) begin
        s_next.sub = 8'h00;
        // one step: ramps move one percent, holds count one of HOLD_STEPS
        unique case (s_reg.st)
          ST_RISE: begin
            if (s_reg.level < peak_lvl) s_next.level = s_reg.level + 7'h01;
            else if (s_reg.level > peak_lvl) s_next.level = s_reg.level - 7'h01;
            else begin
              s_next.st   = ST_PEAK;
              s_next.hold = 7'h00;
            end
          end
          ST_PEAK: begin
            s_next.hold = s_reg.hold + 7'h01;
            if (s_next.hold == 7'(HOLD_STEPS)) s_next.st = ST_FALL;
          end
          ST_FALL: begin
            if (s_reg.level > floor_lvl) s_next.level = s_reg.level - 7'h01;
            else if (s_reg.level < floor_lvl) s_next.level = s_reg.level + 7'h01;
            else begin
              s_next.st   = ST_FLOOR;
              s_next.hold = 7'h00;
            end
          end
          default: begin
            s_next.hold = s_reg.hold + 7'h01;
            if (s_next.hold == 7'(HOLD_STEPS)) begin
              s_next.runs = s_reg.runs - 5'h01;
              s_next.st   = (s_next.runs == 5'h00) ? ST_IDLE : ST_RISE;
              s_next.hold = 7'h00;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '{st: ST_IDLE, level: 7'h00, sub: 8'h00, hold: 7'h00, runs: 5'h00, on: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign led_on_o = s_reg.on;
  assign busy_o   = (s_reg.st != ST_IDLE);

  sequence seq_in_rise;
    s_reg.st == ST_RISE;
  endsequence

  sequence seq_in_peak;
    s_reg.st == ST_PEAK;
  endsequence

  property p_peak_after_rise;
    @(posedge clk_i) disable iff (rst_i)
      (s_reg.st == ST_PEAK && $past(s_reg.st) != ST_PEAK) |-> $past(s_reg.st == ST_RISE);
  endproperty

  a_peak_level_held: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_in_peak |-> s_reg.level == peak_lvl) else $error("peak level differs from code");
  a_floor_level_held: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.st == ST_FLOOR |-> s_reg.level == floor_lvl) else $error("floor level differs from code");
  a_zero_runs_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && cfg_a_i.effect_cycle_count == 3'h0) |=> !busy_o) else $error("zero count started an effect");
  a_peak_from_rise: assert property (p_peak_after_rise)
    else $error("peak entered without ramp up");
  a_rise_slot_used: assert property (@(posedge clk_i) disable iff (rst_i)
    (seq_in_rise ##0 (tick_i && !start_i && s_reg.sub == 8'h00
                      && slots_i[cfg_a_i.rise_duration_sel] > 8'h01))
    |=> $stable(s_reg.level)) else $error("rise stepped before its slot ended");
  a_floor_hold_slot: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_reg.st == ST_FLOOR && tick_i && !start_i && s_reg.sub == 8'h00
     && slots_i[{1'b0, cfg_b_i.floor_hold_sel}] > 8'h01)
    |=> $stable(s_reg.hold)) else $error("floor hold stepped before its slot ended");
  a_step_needs_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    (!tick_i && !start_i) |=> $stable(s_reg.level) && $stable(s_reg.hold)) else $error("step without tick");
  a_pwm_follows_lvl: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> led_on_o == ($past(pwm_cnt_i) < $past(s_reg.level))) else $error("pwm compare wrong");

endmodule

//--- pofade_top.sv
// power-on led fade block: APB register slave, step divider, pwm phase and four group sequencers
// assumes APB master with 32-bit data on the core clock; leds are lit by a low output
module pofade_top
  import pofade_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC  // core cycles per fade step tick
)
(
  input  wire logic                CORE_CLK_I,  // core clock, 50 MHz
  input  wire logic                RST_I,       // synchronous reset, high
  input  wire logic                PSEL_I,      // APB select
  input  wire logic                PENABLE_I,   // APB access phase
  input  wire logic                PWRITE_I,    // APB write
  input  wire logic [11:0]         PADDR_I,     // APB byte address
  input  wire logic [31:0]         PWDATA_I,    // APB write data
  output logic      [31:0]         PRDATA_O,    // APB read data
  output logic                     PREADY_O,    // APB ready
  output logic                     PSLVERR_O,   // APB error, unmapped address
  output logic      [NUM_OUTS-1:0] GPO_N_O      // led outputs, low lit
);

  // the step divider counter is 24 bits wide
  if (TICK_CYCLES < 1 || TICK_CYCLES > 32'h00FF_FFFF) begin : gen_bad_tick
    $error("TICK_CYCLES out of range");
  end

  typedef struct packed {
    logic [7:0][7:0]      cfg;
    pofade_slots_t        slots;
    logic                 start;
    logic                 por_done;
    logic [23:0]          tick_cnt;
    logic                 tick;
    logic [6:0]           pwm_cnt;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    logic [NUM_OUTS-1:0]  gpo_n;
  } pofade_top_t;

  pofade_top_t          t_reg;
  pofade_top_t          t_next;
  logic [NUM_GROUPS-1:0] grp_on;
  logic [NUM_GROUPS-1:0] grp_busy;
  logic [7:0]           idx;
  logic                 setup;
  logic                 wr_take;

  // output index to group: 0 alone, then 1-3, 4-6, 7-9
  function automatic logic [1:0] pofade_group_of(input int unsigned out);
    if (out == 0) pofade_group_of = 2'h0;
    else pofade_group_of = 2'((out - 1) / 3 + 1);
  endfunction

  function automatic logic pofade_mapped(input logic [7:0] i);
    pofade_mapped = (i >= IDX_CFG_A0 && i <= IDX_CFG_B3) ||
                    (i >= IDX_FADE_SLOT && i <= IDX_STATUS);
  endfunction

  assign idx     = PADDR_I[9:2];
  assign setup   = PSEL_I && !PENABLE_I;
  assign wr_take = PSEL_I && PENABLE_I && t_reg.pready && PWRITE_I && !t_reg.pslverr;

  always_comb begin
    t_next       = t_reg;
    t_next.start = 1'b0;
    // step tick divider
    if (t_reg.tick_cnt == 24'(TICK_CYCLES - 1)) begin
      t_next.tick_cnt = 24'h000000;
      t_next.tick     = 1'b1;
    end else begin
      t_next.tick_cnt = t_reg.tick_cnt + 24'h000001;
      t_next.tick     = 1'b0;
    end
    t_next.pwm_cnt = (t_reg.pwm_cnt == 7'(PWM_STEPS - 1)) ? 7'h00 : t_reg.pwm_cnt + 7'h01;
    // the effect is started once by itself after reset; with the reset config of zero runs nothing is lit
    if (!t_reg.por_done) begin
      t_next.por_done = 1'b1;
      t_next.start    = 1'b1;
    end
    // APB: answer prepared in setup, ready during the single access cycle
    t_next.pready  = setup;
    t_next.pslverr = setup && !pofade_mapped(idx);
    t_next.prdata  = 32'h0000_0000;
    if (setup) begin
      if (idx >= IDX_CFG_A0 && idx <= IDX_CFG_B3) begin
        t_next.prdata[7:0] = t_reg.cfg[3'(idx - IDX_CFG_A0)];
      end else if (idx >= IDX_FADE_SLOT && idx < IDX_CTRL) begin
        t_next.prdata[7:0] = t_reg.slots[2'(idx - IDX_FADE_SLOT)];
      end else if (idx == IDX_STATUS) begin
        t_next.prdata[NUM_GROUPS-1:0] = grp_busy;
      end
    end
    if (wr_take) begin
      if (idx >= IDX_CFG_A0 && idx <= IDX_CFG_B3) begin
        t_next.cfg[3'(idx - IDX_CFG_A0)] = PWDATA_I[7:0];
      end else if (idx >= IDX_FADE_SLOT && idx < IDX_CTRL) begin
        t_next.slots[2'(idx - IDX_FADE_SLOT)] = PWDATA_I[7:0];
      end else if (idx == IDX_CTRL && PWDATA_I[CTRL_START_BIT]) begin
        t_next.start = 1'b1;
      end
    end
    for (int unsigned o = 0; o < NUM_OUTS; o++) begin
      t_next.gpo_n[o] = !grp_on[pofade_group_of(o)];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      t_reg <= '{cfg: {8{CFG_RST}}, slots: {4{SLOT_RST}}, start: 1'b0, por_done: 1'b0,
                 tick_cnt: 24'h000000, tick: 1'b0, pwm_cnt: 7'h00, pready: 1'b0,
                 pslverr: 1'b0, prdata: 32'h0000_0000, gpo_n: {NUM_OUTS{1'b1}}};
    end else begin
      t_reg <= t_next;
    end
  end

  // group g uses the pair at 12h+2g and 13h+2g
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : gen_grp
    pofade_seq u_seq (
      .clk_i     (CORE_CLK_I),
      .rst_i     (RST_I),
      .tick_i    (t_reg.tick),
      .start_i   (t_reg.start),
      .cfg_a_i   (pofade_cfg_a_t'(t_reg.cfg[2*g])),
      .cfg_b_i   (pofade_cfg_b_t'(t_reg.cfg[2*g+1])),
      .slots_i   (t_reg.slots),
      .pwm_cnt_i (t_reg.pwm_cnt),
      .led_on_o  (grp_on[g]),
      .busy_o    (grp_busy[g])
    );
  end

  assign PRDATA_O  = t_reg.prdata;
  assign PREADY_O  = t_reg.pready;
  assign PSLVERR_O = t_reg.pslverr;
  assign GPO_N_O   = t_reg.gpo_n;

  sequence seq_apb_setup;
    PSEL_I && !PENABLE_I;
  endsequence

  a_apb_ready_next: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    seq_apb_setup |=> PREADY_O && (PSLVERR_O == !pofade_mapped($past(idx)))) else $error("apb answer wrong");
  a_cfg_write_lands: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (wr_take && idx == IDX_CFG_A2) |=> t_reg.cfg[4] == $past(PWDATA_I[7:0])) else $error("cfg write lost");
  a_group_outputs_match: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    GPO_N_O[3:1] inside {3'b000, 3'b111} && GPO_N_O[9:7] inside {3'b000, 3'b111}) else $error("group split");
  a_por_start_once: assert property (@(posedge CORE_CLK_I)
    $fell(RST_I) |-> ##1 t_reg.start) else $error("no start after reset");

endmodule

//--- pofade_top_tb_top.sv
// bench for the power-on led fade block: apb register checks and measured fade effects
// assumes a 4-cycle step tick and fade slots of 1..4 ticks written over the bus
module pofade_top_tb_top
  import pofade_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  logic                     core_clk = 1'b0;
  logic                     rst;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic                     clr;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic [NUM_OUTS-1:0]      gpo_n;
  logic [NUM_OUTS-1:0][6:0] level;
  logic [NUM_OUTS-1:0][6:0] peak;
  int                       error_cnt = 0;
  int                       checked = 0;
  int                       seed = 32'h90EC128E;
  int                       cyc = 0;

  pofade_top #(.TICK_CYCLES(TICK)) pofade_top_inst (
    .CORE_CLK_I(core_clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .GPO_N_O(gpo_n));
  pofade_led_model pofade_led_model_inst (
    .clk_i(core_clk), .clr_i(clr), .led_n_i(gpo_n), .level_o(level), .peak_o(peak));

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  task print_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 16) begin
      error_cnt++;
      print_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic int pk(input logic [2:0] c);
    int t[8] = '{100, 90, 80, 65, 50, 40, 20, 0};
    return t[c];
  endfunction

  function automatic int fl(input logic [2:0] c);
    int t[8] = '{0, 10, 20, 30, 40, 60, 80, 100};
    return t[c];
  endfunction

  // slot k holds k+1 ticks, so a select code adds one
  function automatic int dur(input logic [7:0] a, input logic [7:0] b, input int n);
    int p;
    int d;
    p = pk(a[5:3]);
    d = p - fl(b[5:3]);
    return TICK * (p * (a[7:6] + 1) + (n - 1) * d * (a[7:6] + 1)
                   + n * (100 * (b[2:1] + 1) + d * (b[7:6] + 1) + 100 * (b[0] + 1)));
  endfunction

  task run_effect(input int g, input logic [7:0] a, input logic [7:0] b, input int n);
    logic [31:0] rd;
    logic        err;
    int          t0;
    int          ex;
    int          e;
    apb(1'b1, IDX_CFG_A0 + 8'(2 * g), {24'h0, a}, rd, err);
    apb(1'b1, IDX_CFG_B0 + 8'(2 * g), {24'h0, b}, rd, err);
    apb(1'b1, IDX_CTRL, 32'h1, rd, err);
    t0 = cyc;
    // let the restart reach the pins before measuring
    repeat (4) @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    e = 0;
    rd = 32'h1 << g;
    while (rd[g] === 1'b1 && e < 8000) begin
      apb(1'b0, IDX_STATUS, 32'h0, rd, err);
      e++;
    end
    if (e >= 8000) begin
      error_cnt++;
      print_verdict;
    end
    t0 = cyc - t0;
    ex = dur(a, b, n);
    check((t0 > ex - ex / 16 - 40 && t0 < ex + ex / 16 + 40) ? ex : t0, ex);
    repeat (250) @(posedge core_clk);
    for (int i = 0; i < NUM_OUTS; i++) begin
      if (((i == 0) ? 0 : (i - 1) / 3 + 1) == g) begin
        check(peak[i], pk(a[5:3]));
        check(level[i], fl(b[5:3]));
      end else begin
        check(peak[i], 0);
      end
    end
    apb(1'b1, IDX_CFG_A0 + 8'(2 * g), 32'h0, rd, err);
    $display("effect on group %0d with %0d runs done", g, n);
  endtask

  initial begin
    logic [31:0] rd;
    logic        err;
    logic [7:0]  a;
    logic [7:0]  b;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    clr = 1'b0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (200) @(posedge core_clk);
    check(gpo_n, 10'h3FF);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, IDX_CFG_A0 + 8'(i), 32'h0, rd, err);
      check(rd, 32'h0);
      a = 8'($random(seed));
      apb(1'b1, IDX_CFG_A0 + 8'(i), {24'($random(seed)), a}, rd, err);
      apb(1'b0, IDX_CFG_A0 + 8'(i), 32'h0, rd, err);
      check(rd, {24'h0, a});
      apb(1'b1, IDX_CFG_A0 + 8'(i), 32'h0, rd, err);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, IDX_FADE_SLOT + 8'(i), 32'h0, rd, err);
      check(rd, {24'h0, SLOT_RST});
      apb(1'b1, IDX_FADE_SLOT + 8'(i), 32'(i + 1), rd, err);
    end
    apb(1'b1, 8'h30, 32'hFF, rd, err);
    check(err, 1'b1);
    apb(1'b0, 8'h30, 32'h0, rd, err);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("register tests done");
    // peak code i with floor code 7-i keeps the floor at or below the peak
    for (int i = 0; i < 8; i++) begin
      a = {2'($random(seed)), 3'(i), 3'h1};
      b = {2'($random(seed)), 3'(7 - i), 3'($random(seed))};
      run_effect(i % 4, a, b, 1);
    end
    run_effect(2, {2'($random(seed)), 6'h12}, {2'($random(seed)), 3'h4, 3'($random(seed))}, 2);
    run_effect(1, 8'h33, 8'h08, 4);
    run_effect(3, 8'h34, 8'h08, 6);
    run_effect(0, 8'h35, 8'h08, 10);
    print_verdict;
  end
endmodule
